// >>> logic/opkc_top.sv
// opkc_top: on pin handling, reset pin control, soft reset scope and key lock
// assumes apb master on pclk, synchronous pin inputs, power state logic outside
//
// Behaviour
// - held button takes selected secondary action
// - button press takes selected primary action
// - every button press sets a sticky status bit, irq when unmasked
// - live button level readable, low reads zero
// - hold timeout selectable one to eight seconds
// - boot data reloaded with each on request when its bit is set
// - soft reset restores defaults except irq_status when scope clear
// - aux reset level in sleep follows bit
// - external reset input masked in sleep
// - reset pin driven low in sleep when its bit is set
// - reset held for selected delay after wake
// - address auto advance follows its bit
// - key value must precede protected writes
// - button and reset fields are key protected
`timescale 1ns/1ps
module opkc_top #(
  parameter int unsigned SECOND_CYCLES = opkc_pkg::SECOND_CYCLES, // cycles in one second
  parameter int unsigned MS_CYCLES     = opkc_pkg::MS_CYCLES      // cycles in one millisecond
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic [31:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // device side inputs
  input  wire logic              button_n,
  input  wire logic              sleep_active,
  input  wire logic              ext_reset_n,
  input  wire logic              on_wake_done,
  input  wire logic              soft_reset,
  // device side outputs
  output opkc_pkg::opkc_req_t    req,
  output opkc_pkg::opkc_rst_t    rst_pins,
  output logic                   address_auto_advance,
  output logic                   irq
);

  // reset pin sequencer states
  typedef enum logic [1:0] {
    RS_HELD,
    RS_DELAY,
    RS_RELEASED
  } opkc_rs_state_t;

  // register storage
  logic [15:0]    on_pin_control;     // writable bits of on_pin_control
  logic [15:0]    reset_control;      // reset control fields
  logic [15:0]    control_interface_config; // control interface options
  logic [15:0]    unlock_key;         // last key written
  logic [1:0]     irq_status;         // sticky event bits
  logic [1:0]     irq_mask;           // enable per event bit
  logic [1:0]     rd_status_snap;     // status bits returned by the current read

  // bus decode
  logic           acc;                // access phase of any transfer
  logic           hit;                // address maps to a register
  logic           wr;                 // accepted write this cycle
  logic           rd_status;          // accepted read of irq_status
  logic           key_ok;             // protected fields unlocked
  logic           soft_clear;         // soft reset clears the map except irq_status

  // button path
  logic           btn_prev_n;         // pin level one cycle ago
  logic           press;              // pin just became asserted
  logic [31:0]    hold_cnt;           // cycles the pin has been held
  logic           hold_done;          // secondary action already taken
  logic           hold_fire;          // hold period reached this cycle
  logic [31:0]    hold_period;        // selected hold period in cycles
  logic           next_on_req;        // on request this cycle
  logic           next_off_req;       // off request this cycle

  // reset pin path
  opkc_rs_state_t rs_state;           // reset sequencer state
  logic [31:0]    rs_cnt;             // cycles left before release
  logic [31:0]    rs_period;          // selected release delay in cycles

  // field views
  logic [1:0]     sec_act;            // button_secondary_action
  logic [1:0]     prim_act;           // button_primary_action
  logic [1:0]     hold_to;            // button_hold_timeout
  logic           reload_boot;        // reload_boot_config_on_power_up
  logic           soft_scope;         // soft_reset_scope
  logic           aux_slp;            // aux_reset_sleep_level
  logic           rst_in_mask;        // reset_input_sleep_mask
  logic           rst_out_slp;        // reset_output_sleep_level
  logic [1:0]     rst_delay_sel;      // reset_release_delay

  // byte address of a register index
  function automatic logic [31:0] reg_addr(input logic [15:0] idx);
    reg_addr = {14'h0000, idx, 2'b00};
  endfunction : reg_addr

  // merge a write into a 16-bit register under byte lanes and writable bits
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  strb,
                                          input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes   = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge16 = (old & ~lanes) | (wdata[15:0] & lanes);
  endfunction : merge16

  // field extraction
  assign sec_act       = on_pin_control[opkc_pkg::POS_SEC_ACT +: 2];
  assign prim_act      = on_pin_control[opkc_pkg::POS_PRIM_ACT +: 2];
  assign hold_to       = on_pin_control[opkc_pkg::POS_HOLD_TO +: 2];
  assign reload_boot   = reset_control[opkc_pkg::POS_RELOAD_BOOT];
  assign soft_scope    = reset_control[opkc_pkg::POS_SOFT_SCOPE];
  assign aux_slp       = reset_control[opkc_pkg::POS_AUX_SLP];
  assign rst_in_mask   = reset_control[opkc_pkg::POS_RST_IN_MASK];
  assign rst_out_slp   = reset_control[opkc_pkg::POS_RST_OUT_SLP];
  assign rst_delay_sel = reset_control[opkc_pkg::POS_RST_DELAY +: 2];

  // address decode for the access phase
  always_comb begin
    if (paddr == reg_addr(opkc_pkg::IDX_ON_PIN_CONTROL)) begin
      hit = 1'b1;
    end else if (paddr == reg_addr(opkc_pkg::IDX_RESET_CONTROL)) begin
      hit = 1'b1;
    end else if (paddr == reg_addr(opkc_pkg::IDX_CONTROL_IF_CFG)) begin
      hit = 1'b1;
    end else if (paddr == reg_addr(opkc_pkg::IDX_UNLOCK_KEY)) begin
      hit = 1'b1;
    end else if (paddr == reg_addr(opkc_pkg::IDX_IRQ_STATUS)) begin
      hit = 1'b1;
    end else if (paddr == reg_addr(opkc_pkg::IDX_IRQ_MASK)) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // zero wait state slave; unmapped addresses answer with an error
  assign acc        = psel & penable;
  assign pready     = 1'b1;
  assign pslverr    = acc & ~hit;
  assign wr         = acc & pwrite & hit;
  assign rd_status  = acc & ~pwrite & (paddr == reg_addr(opkc_pkg::IDX_IRQ_STATUS));
  assign key_ok     = (unlock_key == opkc_pkg::UNLOCK_VALUE);
  assign soft_clear = soft_reset & ~soft_scope;

  // read data captured in the setup phase so it comes from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata         <= 32'h0000_0000;
      rd_status_snap <= 2'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata         <= 32'h0000_0000;
      rd_status_snap <= 2'h0;
      if (paddr == reg_addr(opkc_pkg::IDX_ON_PIN_CONTROL)) begin
        prdata[15:0] <= (on_pin_control & opkc_pkg::WMASK_ON_PIN_CONTROL)
                        | (16'(button_n) << opkc_pkg::POS_LEVEL_STS);
      end else if (paddr == reg_addr(opkc_pkg::IDX_RESET_CONTROL)) begin
        prdata[15:0] <= reset_control;
      end else if (paddr == reg_addr(opkc_pkg::IDX_CONTROL_IF_CFG)) begin
        prdata[15:0] <= control_interface_config;
      end else if (paddr == reg_addr(opkc_pkg::IDX_UNLOCK_KEY)) begin
        prdata[15:0] <= unlock_key;
      end else if (paddr == reg_addr(opkc_pkg::IDX_IRQ_STATUS)) begin
        prdata[1:0]    <= irq_status;
        rd_status_snap <= irq_status;
      end else if (paddr == reg_addr(opkc_pkg::IDX_IRQ_MASK)) begin
        prdata[1:0] <= irq_mask;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // unlock key register, never guarded itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_key <= opkc_pkg::RST_UNLOCK_KEY;
    end else if (soft_clear) begin
      // map except irq_status cleared by soft reset
      unlock_key <= opkc_pkg::RST_UNLOCK_KEY;
    end else if (wr && paddr == reg_addr(opkc_pkg::IDX_UNLOCK_KEY)) begin
      unlock_key <= merge16(unlock_key, pwdata, pstrb, 16'hFFFF);
    end
  end

  // button control register, writes taken only while unlocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_pin_control <= opkc_pkg::RST_ON_PIN_CONTROL;
    end else if (soft_clear) begin
      on_pin_control <= opkc_pkg::RST_ON_PIN_CONTROL;
    end else if (wr && key_ok && paddr == reg_addr(opkc_pkg::IDX_ON_PIN_CONTROL)) begin
      on_pin_control <= merge16(on_pin_control, pwdata, pstrb,
                                opkc_pkg::WMASK_ON_PIN_CONTROL);
    end
  end

  // reset control register, writes taken only while unlocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_control <= opkc_pkg::RST_RESET_CONTROL;
    end else if (soft_clear) begin
      reset_control <= opkc_pkg::RST_RESET_CONTROL;
    end else if (wr && key_ok && paddr == reg_addr(opkc_pkg::IDX_RESET_CONTROL)) begin
      reset_control <= merge16(reset_control, pwdata, pstrb,
                               opkc_pkg::WMASK_RESET_CONTROL);
    end
  end

  // control interface options, not guarded by the key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_interface_config <= opkc_pkg::RST_CONTROL_IF_CFG;
    end else if (soft_clear) begin
      control_interface_config <= opkc_pkg::RST_CONTROL_IF_CFG;
    end else if (wr && paddr == reg_addr(opkc_pkg::IDX_CONTROL_IF_CFG)) begin
      control_interface_config <= merge16(control_interface_config, pwdata, pstrb,
                                          opkc_pkg::WMASK_CONTROL_IF_CFG);
    end
  end

  assign address_auto_advance = control_interface_config[opkc_pkg::POS_AUTO_ADV];

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= opkc_pkg::RST_IRQ;
    end else if (soft_clear) begin
      irq_mask <= opkc_pkg::RST_IRQ;
    end else if (wr && pstrb[0] && paddr == reg_addr(opkc_pkg::IDX_IRQ_MASK)) begin
      irq_mask <= pwdata[1:0];
    end
  end

  // sticky status: new events win over the clear done by a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= opkc_pkg::RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~(rd_status ? rd_status_snap : 2'h0))
                    | (2'(press) << opkc_pkg::POS_IRQ_PRIMARY)
                    | (2'(hold_fire && sec_act == opkc_pkg::ACT_IGNORE_OR_IRQ)
                       << opkc_pkg::POS_IRQ_SECONDARY);
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // button edge detect; pin is active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_prev_n <= 1'b1;
    end else begin
      btn_prev_n <= button_n;
    end
  end
  assign press = btn_prev_n & ~button_n;

  assign hold_period = SECOND_CYCLES << hold_to;

  // hold counter: counts while held, clears on release, fires once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt  <= 32'h0000_0000;
      hold_done <= 1'b0;
    end else if (button_n) begin
      hold_cnt  <= 32'h0000_0000;
      hold_done <= 1'b0;
    end else if (!hold_done) begin
      if (hold_fire) begin
        hold_done <= 1'b1;
      end else begin
        hold_cnt <= hold_cnt + 32'h0000_0001;
      end
    end
  end
  assign hold_fire = ~button_n & ~hold_done & (hold_cnt == hold_period - 32'h0000_0001);

  // request decode from primary and secondary actions
  always_comb begin
    next_on_req  = press && (prim_act == opkc_pkg::ACT_ON_REQUEST);
    next_off_req = press && (prim_act == opkc_pkg::ACT_OFF_REQUEST);
    if (hold_fire && sec_act == opkc_pkg::ACT_ON_REQUEST) begin
      next_on_req = 1'b1;
    end else if (hold_fire && sec_act == opkc_pkg::ACT_OFF_REQUEST) begin
      next_off_req = 1'b1;
    end
  end

  // request pulses, one cycle each, from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
    end else begin
      req.on_request  <= next_on_req;
      req.off_request <= next_off_req;
      req.boot_reload <= next_on_req & reload_boot;
    end
  end

  always_comb begin
    case (rst_delay_sel)
      2'h0:    rs_period = 32'(MS_CYCLES * opkc_pkg::DELAY_MS_0);
      2'h1:    rs_period = 32'(MS_CYCLES * opkc_pkg::DELAY_MS_1);
      2'h2:    rs_period = 32'(MS_CYCLES * opkc_pkg::DELAY_MS_2);
      default: rs_period = 32'(MS_CYCLES * opkc_pkg::DELAY_MS_3);
    endcase
  end

  // reset sequencer: held from power up until a sequence ends plus the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_state <= RS_HELD;
      rs_cnt   <= 32'h0000_0000;
    end else if (on_wake_done) begin
      rs_state <= RS_DELAY;
      rs_cnt   <= rs_period - 32'h0000_0001;
    end else begin
      case (rs_state)
        RS_HELD: begin
          rs_state <= RS_HELD;
        end
        RS_DELAY: begin
          if (rs_cnt == 32'h0000_0000) begin
            rs_state <= RS_RELEASED;
          end else begin
            rs_cnt <= rs_cnt - 32'h0000_0001;
          end
        end
        default: begin
          rs_state <= RS_RELEASED;
        end
      endcase
    end
  end

  // reset pin group, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pins <= '0;
    end else begin
      if (sleep_active) begin
        rst_pins.reset_pin_n <= ~rst_out_slp;
      end else begin
        rst_pins.reset_pin_n <= (rs_state == RS_RELEASED);
      end
      rst_pins.aux_reset      <= sleep_active & aux_slp;
      rst_pins.ext_reset_seen <= ~ext_reset_n & ~(sleep_active & rst_in_mask);
    end
  end

endmodule : opkc_top

// >>> logic/opkc_pkg.sv
// opkc_pkg: constants and carrier types for the on pin, reset and key block
// assumes a single 100 MHz clock and a 32-bit apb register bus
package opkc_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ON_PIN_CONTROL   = 16'h4005;
  localparam logic [15:0] IDX_RESET_CONTROL    = 16'h4006;
  localparam logic [15:0] IDX_CONTROL_IF_CFG   = 16'h4007;
  localparam logic [15:0] IDX_UNLOCK_KEY       = 16'h4008;
  localparam logic [15:0] IDX_IRQ_STATUS       = 16'h4010;
  localparam logic [15:0] IDX_IRQ_MASK         = 16'h4011;

  // on_pin_control field positions
  localparam int unsigned POS_SEC_ACT          = 8;
  localparam int unsigned POS_PRIM_ACT         = 4;
  localparam int unsigned POS_LEVEL_STS        = 3;
  localparam int unsigned POS_HOLD_TO          = 0;
  // reset_control field positions
  localparam int unsigned POS_RELOAD_BOOT      = 15;
  localparam int unsigned POS_SOFT_SCOPE       = 10;
  localparam int unsigned POS_AUX_SLP          = 6;
  localparam int unsigned POS_RST_IN_MASK      = 5;
  localparam int unsigned POS_RST_OUT_SLP      = 4;
  localparam int unsigned POS_RST_DELAY        = 0;
  // control_interface_config and interrupt field positions
  localparam int unsigned POS_AUTO_ADV         = 2;
  localparam int unsigned POS_IRQ_PRIMARY      = 0;
  localparam int unsigned POS_IRQ_SECONDARY    = 1;

  // reset values and writable bits
  localparam logic [15:0] RST_ON_PIN_CONTROL   = 16'h0100;
  localparam logic [15:0] RST_RESET_CONTROL    = 16'h8473;
  localparam logic [15:0] RST_CONTROL_IF_CFG   = 16'h0004;
  localparam logic [15:0] RST_UNLOCK_KEY       = 16'h0000;
  localparam logic [1:0]  RST_IRQ              = 2'h0;
  localparam logic [15:0] WMASK_ON_PIN_CONTROL = 16'h0333;
  localparam logic [15:0] WMASK_RESET_CONTROL  = 16'h8473;
  localparam logic [15:0] WMASK_CONTROL_IF_CFG = 16'h0004;
  localparam logic [15:0] UNLOCK_VALUE         = 16'h9716;

  // button action encodings
  localparam logic [1:0]  ACT_IGNORE_OR_IRQ    = 2'h0;
  localparam logic [1:0]  ACT_ON_REQUEST       = 2'h1;
  localparam logic [1:0]  ACT_OFF_REQUEST      = 2'h2;

  // timing: base units and derived cycle counts
  localparam int unsigned CLK_HZ               = 100_000_000;
  localparam int unsigned HOLD_BASE_S          = 1;
  localparam int unsigned SECOND_CYCLES        = HOLD_BASE_S * CLK_HZ;
  localparam int unsigned MS_CYCLES            = CLK_HZ / 1000;
  localparam int unsigned DELAY_MS_0           = 3;
  localparam int unsigned DELAY_MS_1           = 11;
  localparam int unsigned DELAY_MS_2           = 51;
  localparam int unsigned DELAY_MS_3           = 101;

  // power requests issued toward the power state logic
  typedef struct packed {
    logic on_request;
    logic off_request;
    logic boot_reload;
  } opkc_req_t;

  // reset pin group driven toward the board
  typedef struct packed {
    logic reset_pin_n;
    logic aux_reset;
    logic ext_reset_seen;
  } opkc_rst_t;

endpackage : opkc_pkg

// >>> dv/opkc_asserts.sv
// opkc_asserts: port level timing checks for opkc_top
// assumes one domain, pclk, with presetn as its asynchronous reset
`timescale 1ns/1ps
module opkc_asserts #(
  parameter int unsigned MS_CYCLES = 4 // cycles in one millisecond
) (
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // apb
  input wire logic [31:0]         paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pslverr,
  // device side
  input wire logic                button_n,
  input wire logic                sleep_active,
  input wire logic                ext_reset_n,
  input wire logic                on_wake_done,
  input wire logic                soft_reset,
  input wire opkc_pkg::opkc_req_t req,
  input wire opkc_pkg::opkc_rst_t rst_pins,
  input wire logic                address_auto_advance
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] wake_cnt; // cycles since the last wake pulse
  // saturating count from the last wake pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wake_cnt <= 16'h0000;
    else if (on_wake_done) wake_cnt <= 16'h0000;
    else if (wake_cnt != 16'hFFFF) wake_cnt <= wake_cnt + 16'h0001;
  end
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside an access phase");
  a_err_unmapped: assert property (psel && penable && paddr == 32'h0001_0024 |-> pslverr)
    else $error("no error response for an unmapped address");
  a_req_pulse: assert property (
    req.on_request || req.off_request |=> !req.on_request && !req.off_request)
    else $error("power request longer than one cycle");
  // reload rides on an on request
  a_boot_with_on: assert property (req.boot_reload |-> req.on_request)
    else $error("boot reload without on request");
  a_req_from_button: assert property (
    req.on_request || req.off_request |-> !$past(button_n) || !$past(button_n, 2))
    else $error("power request without a pressed button");
  // level moves only by write or soft reset
  a_adv_by_write: assert property ($changed(address_auto_advance) |->
    $past(psel && penable && pwrite && paddr == 32'h0001_001C) ||
    $past(soft_reset) || $past(soft_reset, 2))
    else $error("auto advance changed without a cause");
  // a released input is never seen
  a_ext_seen_idle: assert property ($past(ext_reset_n) |-> !rst_pins.ext_reset_seen)
    else $error("external reset seen while released");
  // pin held through the early delay
  a_wake_hold: assert property (
    (on_wake_done && !sleep_active && !rst_pins.reset_pin_n) ##1
    (!on_wake_done && !sleep_active)[*8] |-> !rst_pins.reset_pin_n)
    else $error("reset pin released too early");
  // release never before the shortest delay
  a_wake_min: assert property (
    $rose(rst_pins.reset_pin_n) && !sleep_active && !$past(sleep_active) |->
    wake_cnt >= 16'(3 * MS_CYCLES - 2))
    else $error("reset pin released before shortest delay");
endmodule : opkc_asserts

bind opkc_top opkc_asserts #(.MS_CYCLES(MS_CYCLES)) u_asserts (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pslverr(pslverr), .button_n(button_n), .sleep_active(sleep_active),
  .ext_reset_n(ext_reset_n), .on_wake_done(on_wake_done), .soft_reset(soft_reset),
  .req(req), .rst_pins(rst_pins), .address_auto_advance(address_auto_advance));

// >>> dv/opkc_host.sv
// opkc_host: apb master standing for the host processor
// assumes the slave may insert wait states; waits on pready at rising edges
`timescale 1ns/1ps
module opkc_host (
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic [31:0]      paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus from time zero
  initial begin
    paddr   = 32'h0000_0000;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
  end
  // one transfer; the byte address is four times the index
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd, output logic err);
    @(posedge pclk);
    paddr  <= {14'h0000, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {16'h0000, wd};
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[15:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released data lines do not keep the last value
    pwdata  <= ~pwdata;
  endtask : xfer
endmodule : opkc_host

// >>> dv/opkc_top_tb.sv
// opkc_top_tb: register, button, sleep and release delay tests
// assumes opkc_top with short second and millisecond counts
`timescale 1ns/1ps
module opkc_top_tb;
  localparam int unsigned SEC = 16; // cycles in one second
  localparam int unsigned MS  = 4;  // cycles in one millisecond
  localparam logic [15:0] OPC = opkc_pkg::IDX_ON_PIN_CONTROL;
  localparam logic [15:0] RC  = opkc_pkg::IDX_RESET_CONTROL;
  localparam logic [15:0] CFG = opkc_pkg::IDX_CONTROL_IF_CFG;
  localparam logic [15:0] KEY = opkc_pkg::IDX_UNLOCK_KEY;
  localparam logic [15:0] STS = opkc_pkg::IDX_IRQ_STATUS;
  localparam logic [15:0] MSK = opkc_pkg::IDX_IRQ_MASK;
  logic pclk = 1'b0, presetn = 1'b0, button_n = 1'b1, sleep_active = 1'b0;
  logic ext_reset_n = 1'b1, on_wake_done = 1'b0, soft_reset = 1'b0;
  logic [31:0] paddr, pwdata, prdata;
  logic        psel, penable, pwrite, pready, pslverr, adv, irq, er;
  logic [3:0]  pstrb;
  logic [15:0] rv, v;
  opkc_pkg::opkc_req_t req;
  opkc_pkg::opkc_rst_t rst_pins;
  int num_errors = 0, num_checks = 0, n_on = 0, n_off = 0, n_boot = 0;
  int e_on = 0, e_off = 0, p, n, lo;
  int dms[4] = '{opkc_pkg::DELAY_MS_0, opkc_pkg::DELAY_MS_1,
                 opkc_pkg::DELAY_MS_2, opkc_pkg::DELAY_MS_3};
  always #5 pclk = ~pclk;
  opkc_host host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  opkc_top #(.SECOND_CYCLES(SEC), .MS_CYCLES(MS)) uut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .button_n(button_n), .sleep_active(sleep_active), .ext_reset_n(ext_reset_n),
    .on_wake_done(on_wake_done), .soft_reset(soft_reset), .req(req), .rst_pins(rst_pins),
    .address_auto_advance(adv), .irq(irq));
  // count request pulses seen at each edge
  always @(posedge pclk) begin
    if (req.on_request === 1'b1) n_on++;
    if (req.off_request === 1'b1) n_off++;
    if (req.boot_reload === 1'b1) n_boot++;
  end
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t bit %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask : tick
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    host.xfer(1'b1, i, d, rv, er);
  endtask : wr
  task automatic rd(input logic [15:0] i, input logic [15:0] e);
    host.xfer(1'b0, i, 16'h0000, rv, er);
    chk16(rv, e);
  endtask : rd
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    tick(4);
    presetn <= 1'b1;
  endtask : do_reset
  // short press of c cycles, then settle
  task automatic press(input int c);
    @(posedge pclk);
    button_n <= 1'b0;
    tick(c);
    button_n <= 1'b1;
    tick(3);
  endtask : press
  task automatic srst();
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
  endtask : srst
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // hang guard
  initial begin
    #500_000;
    num_errors++;
    conclude();
  end
  initial begin
    do_reset();
    #1 chk1(adv, 1'b1);
    rd(OPC, 16'h0108);
    rd(RC, 16'h8473);
    rd(CFG, 16'h0004);
    rd(STS, 16'h0000);
    rd(MSK, 16'h0000);
    host.xfer(1'b0, 16'h4009, 16'h0000, rv, er);
    chk1(er, 1'b1);
    wr(KEY, 16'h1234);
    wr(OPC, 16'h0011);
    rd(OPC, 16'h0108);
    wr(RC, 16'h0000);
    rd(RC, 16'h8473);
    wr(KEY, opkc_pkg::UNLOCK_VALUE);
    rd(KEY, 16'h9716);
    wr(MSK, 16'h0003);
    // every action code and timeout, short then long holds
    for (int t = 0; t < 4; t++) begin
      p = 3 - t;
      v = 16'((t << 8) | (p << 4) | t);
      wr(OPC, v);
      rd(OPC, v | 16'h0008);
      press(4);
      e_on += int'(p == 1);
      e_off += int'(p == 2);
      rd(STS, 16'h0001);
      @(posedge pclk);
      button_n <= 1'b0;
      rd(OPC, v);
      tick((SEC << t) - 4);
      chk16(16'(n_on + n_off), 16'(e_on + e_off + int'(p == 1 || p == 2)));
      tick(8);
      button_n <= 1'b1;
      tick(3);
      e_on += int'(p == 1) + int'(t == 1);
      e_off += int'(p == 2) + int'(t == 2);
      #1 chk1(irq, 1'b1);
      rd(STS, (t == 0) ? 16'h0003 : 16'h0001);
      chk16(16'(n_on), 16'(e_on));
      chk16(16'(n_off), 16'(e_off));
      chk16(16'(n_boot), 16'(e_on));
      @(posedge pclk);
      #1 chk1(irq, 1'b0);
    end
    // reload disabled
    wr(RC, 16'h0473);
    wr(OPC, 16'h0010);
    press(4);
    chk16(16'(n_on - n_boot), 16'h0001);
    rd(STS, 16'h0001);
    // sleep levels and input mask
    @(posedge pclk);
    sleep_active <= 1'b1;
    ext_reset_n <= 1'b0;
    tick(3);
    #1 chk1(rst_pins.reset_pin_n, 1'b0);
    chk1(rst_pins.aux_reset, 1'b1);
    chk1(rst_pins.ext_reset_seen, 1'b0);
    wr(RC, 16'h0403);
    tick(2);
    #1 chk1(rst_pins.reset_pin_n, 1'b1);
    chk1(rst_pins.aux_reset, 1'b0);
    chk1(rst_pins.ext_reset_seen, 1'b1);
    @(posedge pclk);
    sleep_active <= 1'b0;
    tick(3);
    ext_reset_n <= 1'b1;
    #1 chk1(rst_pins.ext_reset_seen, 1'b1);
    // auto advance and soft reset scope
    wr(CFG, 16'h0000);
    #1 chk1(adv, 1'b0);
    srst();
    rd(CFG, 16'h0000);
    wr(RC, 16'h0003);
    srst();
    rd(CFG, 16'h0004);
    rd(KEY, 16'h0000);
    rd(RC, 16'h8473);
    rd(MSK, 16'h0000);
    press(4);
    #1 chk1(irq, 1'b0);
    rd(STS, 16'h0001);
    // release delay for each code, from a fresh reset
    for (int d = 0; d < 4; d++) begin
      do_reset();
      wr(KEY, opkc_pkg::UNLOCK_VALUE);
      wr(RC, 16'h8470 | 16'(d));
      #1 chk1(rst_pins.reset_pin_n, 1'b0);
      @(posedge pclk);
      on_wake_done <= 1'b1;
      @(posedge pclk);
      on_wake_done <= 1'b0;
      n = 1;
      while (rst_pins.reset_pin_n !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      lo = MS * dms[d];
      chk1(n >= lo && n <= lo + 3, 1'b1);
    end
    conclude();
  end
endmodule : opkc_top_tb
